/* logic/dsr_pkg.sv */
// package of the dma and scsi status register bank: offsets, bit positions, reset values, carriers
// assumes a single 100 MHz core clock and an axi4-lite master with 8-bit byte addresses
package dsr_pkg;
    // =====================================================================
    // register map (index; byte address is four times the index)
    localparam int ADDR_W = 8;
    localparam logic [5:0] DMA_STATUS_IDX = 6'h0C;
    localparam logic [5:0] SCSI_STATUS_ZERO_IDX = 6'h0D;
    localparam logic [5:0] DMA_INT_ENABLE_IDX = 6'h20;
    localparam logic [5:0] CONTROL_IDX = 6'h21;
    localparam logic [7:0] DMA_STATUS_RST = 8'h80;
    localparam logic [7:0] SCSI_STATUS_ZERO_RST = 8'h00;
    localparam logic [7:0] DMA_INT_ENABLE_RST = 8'h00;
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] STATUS_INT_MASK = 8'h7F;
    localparam logic [7:0] CONTROL_WMASK = 8'h4F;
    // =====================================================================
    // dma status bits
    localparam int DFE_BIT = 7;
    localparam int MASTER_PARITY_ERROR_FLAG_BIT = 6;
    localparam int BF_BIT = 5;
    localparam int ABORTED_FLAG_BIT = 4;
    localparam int SSI_BIT = 3;
    localparam int SIR_BIT = 2;
    localparam int EXTRA_PARITY_ERROR_FLAG_BIT = 1;
    localparam int IID_BIT = 0;
    // control bits
    localparam int CTL_SSTEP_BIT = 0;
    localparam int CTL_FULL_ARB_BIT = 1;
    localparam int CTL_MPEE_BIT = 3;
    localparam int CTL_SRST_BIT = 6;
    localparam int CTL_ABORT_BIT = 7;
    // =====================================================================
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // =====================================================================
    // instruction decode
    localparam logic [1:0] TYPE_BLOCK = 2'h0;
    localparam logic [1:0] TYPE_XFER = 2'h2;
    localparam logic [1:0] TYPE_MEM = 2'h3;
    localparam int LS_BIT = 5;
    localparam logic [7:0] LS_RSVD_MASK = 8'h0C;
    localparam logic [7:0] MM_RSVD_MASK = 8'h3E;
    localparam logic [2:0] XFER_OP_MAX = 3'h3;
    localparam int WAIT_VALID_BIT = 16;
    localparam int CMP_PHASE_BIT = 17;
    localparam int CMP_DATA_BIT = 18;
    localparam int CARRY_BIT = 21;
    localparam int RSVD22_BIT = 22;
    localparam logic [23:0] LS_MIN = 24'h000001;
    localparam logic [23:0] LS_MAX = 24'h000004;
    localparam logic [3:0] DWORD_BYTES = 4'h4;
    // =====================================================================
    // carriers
    typedef enum logic [1:0] {ARB_IDLE, ARB_RUN, ARB_LOST, ARB_WON} dsr_arb_t;
    typedef struct packed {
        logic awvalid; logic [ADDR_W-1:0] awaddr; logic wvalid; logic [31:0] wdata; logic [3:0] wstrb;
        logic bready; logic arvalid; logic [ADDR_W-1:0] araddr; logic rready;
    } dsr_axi_req_t;
    typedef struct packed {
        logic awready; logic wready; logic bvalid; logic [1:0] bresp;
        logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
    } dsr_axi_rsp_t;
    typedef struct packed {
        logic fifo_empty; logic master_parity_err; logic bus_fault; logic abort_done; logic instr_done_ok;
        logic int_instr_true; logic extra_parity_err; logic illegal_opcode; logic wait_disc_req;
    } dsr_evt_t;
    typedef struct packed {
        logic valid; logic [7:0] cmd; logic [23:0] dbc; logic target_mode; logic mem_is_op_regs;
        logic [1:0] reg_addr; logic [1:0] mem_addr; logic [1:0] src_addr; logic [1:0] dst_addr;
    } dsr_instr_t;
    typedef struct packed {
        logic in_latch_low_full; logic out_hold_low_full; logic out_latch_low_full;
        logic arb_request; logic bus_free; logic arb_win;
    } dsr_scsi_t;
    typedef struct packed {
        logic aw_have; logic w_have; logic [ADDR_W-1:0] awaddr; logic [7:0] wdata; logic wstrb0;
        logic awready; logic wready; logic bvalid; logic [1:0] bresp;
        logic arready; logic rvalid; logic [7:0] rdata; logic [1:0] rresp;
        logic [7:0] dma_status; logic [7:0] scsi_status_zero; logic [7:0] dma_interrupt_enable;
        logic [7:0] control; logic pending; logic abort_req;
        logic rst_s1; logic rst_s2; logic sdp_s1; logic sdp_s2; logic sel_s1; logic sel_s2;
        dsr_arb_t arb;
    } dsr_state_t;
    localparam dsr_state_t STATE_RST = '{
        aw_have: 1'b0, w_have: 1'b0, awaddr: 8'h00, wdata: 8'h00, wstrb0: 1'b0,
        awready: 1'b0, wready: 1'b0, bvalid: 1'b0, bresp: 2'h0,
        arready: 1'b0, rvalid: 1'b0, rdata: 8'h00, rresp: 2'h0,
        dma_status: DMA_STATUS_RST, scsi_status_zero: SCSI_STATUS_ZERO_RST,
        dma_interrupt_enable: DMA_INT_ENABLE_RST, control: CONTROL_RST, pending: 1'b0, abort_req: 1'b0,
        rst_s1: 1'b1, rst_s2: 1'b1, sdp_s1: 1'b1, sdp_s2: 1'b1, sel_s1: 1'b1, sel_s2: 1'b1,
        arb: ARB_IDLE
    };
endpackage

/* logic/dsr_status_regs.sv */
// dma status and scsi status zero register bank with axi4-lite slave
// assumes event and instruction inputs are on aclk; scsi pins are asynchronous and synchronised here
`timescale 1ns/1ps
`default_nettype none

module dsr_status_regs (
    input wire logic aclk,
    input wire logic aresetn,
    input wire dsr_pkg::dsr_axi_req_t s_axi_i,
    output var dsr_pkg::dsr_axi_rsp_t s_axi_o,
    input wire dsr_pkg::dsr_evt_t evt_i,
    input wire dsr_pkg::dsr_instr_t instr_i,
    input wire dsr_pkg::dsr_scsi_t scsi_i,
    input wire logic scsi_rst_n,
    input wire logic scsi_low_byte_parity_line_n,
    input wire logic scsi_sel_n,
    output logic dma_interrupt_pending,
    output logic abort_request
);
    import dsr_pkg::*;

    // =====================================================================
    // decode helpers
    function automatic logic [5:0] reg_index(input logic [ADDR_W-1:0] addr);
        reg_index = addr[ADDR_W-1:2];
    endfunction

    function automatic logic illegal_check(input dsr_instr_t i);
        logic bad;
        logic [3:0] cnt_end;
        bad = 1'b0;
        cnt_end = {2'h0, i.mem_addr} + i.dbc[3:0];
        case (i.cmd[7:6])
            TYPE_BLOCK: begin
                bad = (i.dbc == 24'h000000);
            end
            TYPE_XFER: begin
                bad = (i.cmd[5:3] > XFER_OP_MAX)
                    | (i.target_mode & (i.dbc[CMP_DATA_BIT] | i.dbc[CMP_PHASE_BIT]))
                    | (i.dbc[CARRY_BIT] & (i.dbc[CMP_DATA_BIT] | i.dbc[CMP_PHASE_BIT]))
                    | i.dbc[RSVD22_BIT]
                    | (i.target_mode & i.dbc[WAIT_VALID_BIT]);
            end
            TYPE_MEM: begin
                if (i.cmd[LS_BIT]) begin
                    bad = i.mem_is_op_regs
                        | (i.reg_addr != i.mem_addr)
                        | (|(i.cmd & LS_RSVD_MASK))
                        | (i.dbc < LS_MIN) | (i.dbc > LS_MAX)
                        | (cnt_end > DWORD_BYTES);
                end else begin
                    bad = (|(i.cmd & MM_RSVD_MASK)) | (i.src_addr != i.dst_addr);
                end
            end
            default: begin
                bad = 1'b0;
            end
        endcase
        illegal_check = bad;
    endfunction

    // =====================================================================
    // state
    dsr_state_t st_q;
    dsr_state_t st_d;

    logic aw_fire;
    logic w_fire;
    logic ar_fire;
    logic rd_dma_fire;
    logic [7:0] dma_set;

    assign aw_fire = s_axi_i.awvalid & st_q.awready;
    assign w_fire = s_axi_i.wvalid & st_q.wready;
    assign ar_fire = s_axi_i.arvalid & st_q.arready;
    assign rd_dma_fire = ar_fire & (reg_index(s_axi_i.araddr) == DMA_STATUS_IDX);

    // =====================================================================
    // event sources of the dma status register
    assign dma_set[DFE_BIT] = 1'b0;
    assign dma_set[MASTER_PARITY_ERROR_FLAG_BIT] = evt_i.master_parity_err & st_q.control[CTL_MPEE_BIT];
    assign dma_set[BF_BIT] = evt_i.bus_fault;
    assign dma_set[ABORTED_FLAG_BIT] = evt_i.abort_done & st_q.abort_req;
    assign dma_set[SSI_BIT] = evt_i.instr_done_ok & st_q.control[CTL_SSTEP_BIT];
    assign dma_set[SIR_BIT] = evt_i.int_instr_true;
    assign dma_set[EXTRA_PARITY_ERROR_FLAG_BIT] = evt_i.extra_parity_err;
    assign dma_set[IID_BIT] = evt_i.illegal_opcode | evt_i.wait_disc_req
        | (instr_i.valid & illegal_check(instr_i));

    // =====================================================================
    // next state
    always_comb begin
        st_d = st_q;
        // pin synchronisers
        st_d.rst_s1 = scsi_rst_n;
        st_d.rst_s2 = st_q.rst_s1;
        st_d.sdp_s1 = scsi_low_byte_parity_line_n;
        st_d.sdp_s2 = st_q.sdp_s1;
        st_d.sel_s1 = scsi_sel_n;
        st_d.sel_s2 = st_q.sel_s1;

        // sticky dma status bits 6 to 0: set wins over the read clear; DFE follows fifo_empty
        st_d.dma_status[6:0] = (st_q.dma_status[6:0] & ~(rd_dma_fire ? st_q.dma_status[6:0] : 7'h00))
            | dma_set[6:0];
        st_d.dma_status[DFE_BIT] = evt_i.fifo_empty;

        // abort request handshake
        if (evt_i.abort_done) begin
            st_d.abort_req = 1'b0;
        end

        // arbitration tracker
        case (st_q.arb)
            ARB_RUN: begin
                if (!st_q.sel_s2) begin
                    st_d.arb = ARB_LOST;
                end else if (scsi_i.arb_win) begin
                    st_d.arb = st_q.control[CTL_FULL_ARB_BIT] ? ARB_WON : ARB_IDLE;
                end else if (!scsi_i.arb_request) begin
                    st_d.arb = ARB_IDLE;
                end
            end
            ARB_IDLE, ARB_LOST, ARB_WON: begin
                if (scsi_i.arb_request & scsi_i.bus_free) begin
                    st_d.arb = ARB_RUN;
                end
            end
            default: begin
                st_d.arb = ARB_IDLE;
            end
        endcase

        // axi write channel
        if (aw_fire) begin
            st_d.aw_have = 1'b1;
            st_d.awaddr = s_axi_i.awaddr;
        end
        if (w_fire) begin
            st_d.w_have = 1'b1;
            st_d.wdata = s_axi_i.wdata[7:0];
            st_d.wstrb0 = s_axi_i.wstrb[0];
        end
        if (st_q.bvalid & s_axi_i.bready) begin
            st_d.bvalid = 1'b0;
        end
        if (st_d.aw_have & st_d.w_have & !st_q.bvalid) begin
            st_d.aw_have = 1'b0;
            st_d.w_have = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = RESP_OKAY;
            case (reg_index(st_d.awaddr))
                DMA_INT_ENABLE_IDX: begin
                    if (st_d.wstrb0) begin
                        st_d.dma_interrupt_enable = st_d.wdata & STATUS_INT_MASK;
                    end
                end
                CONTROL_IDX: begin
                    if (st_d.wstrb0) begin
                        st_d.control = st_d.wdata & CONTROL_WMASK;
                        if (st_d.wdata[CTL_ABORT_BIT]) begin
                            st_d.abort_req = 1'b1;
                        end
                    end
                end
                DMA_STATUS_IDX, SCSI_STATUS_ZERO_IDX: begin
                    st_d.bresp = RESP_SLVERR;
                end
                default: begin
                    st_d.bresp = RESP_DECERR;
                end
            endcase
        end
        st_d.awready = !st_d.aw_have & !st_d.bvalid;
        st_d.wready = !st_d.w_have & !st_d.bvalid;

        // axi read channel
        if (st_q.rvalid & s_axi_i.rready) begin
            st_d.rvalid = 1'b0;
        end
        if (ar_fire) begin
            st_d.rvalid = 1'b1;
            st_d.rresp = RESP_OKAY;
            case (reg_index(s_axi_i.araddr))
                DMA_STATUS_IDX: st_d.rdata = st_q.dma_status;
                SCSI_STATUS_ZERO_IDX: st_d.rdata = st_q.scsi_status_zero;
                DMA_INT_ENABLE_IDX: st_d.rdata = st_q.dma_interrupt_enable;
                CONTROL_IDX: st_d.rdata = st_q.control;
                default: begin
                    st_d.rdata = 8'h00;
                    st_d.rresp = RESP_DECERR;
                end
            endcase
        end
        st_d.arready = !st_d.rvalid;

        // masked pending flag, dropped when the read clear empties the enabled bits
        st_d.pending = |(st_d.dma_status & st_d.dma_interrupt_enable & STATUS_INT_MASK);

        // scsi status zero, all live
        st_d.scsi_status_zero = {
            scsi_i.in_latch_low_full,
            scsi_i.out_hold_low_full,
            scsi_i.out_latch_low_full,
            st_d.arb == ARB_RUN,
            st_d.arb == ARB_LOST,
            st_d.arb == ARB_WON,
            ~st_q.rst_s2 | st_d.control[CTL_SRST_BIT],
            ~st_q.sdp_s2
        };
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= STATE_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // =====================================================================
    // outputs
    assign s_axi_o.awready = st_q.awready;
    assign s_axi_o.wready = st_q.wready;
    assign s_axi_o.bvalid = st_q.bvalid;
    assign s_axi_o.bresp = st_q.bresp;
    assign s_axi_o.arready = st_q.arready;
    assign s_axi_o.rvalid = st_q.rvalid;
    assign s_axi_o.rdata = {24'h000000, st_q.rdata};
    assign s_axi_o.rresp = st_q.rresp;
    assign dma_interrupt_pending = st_q.pending;
    assign abort_request = st_q.abort_req;

    // =====================================================================
    // assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_dma_read_quiet;
        rd_dma_fire && (dma_set[6:0] == 7'h00);
    endsequence
    sequence s_arb_seen_sel;
        (st_q.arb == ARB_RUN) && !st_q.sel_s2;
    endsequence

    property p_read_clear;
        s_dma_read_quiet |=> (st_q.dma_status[6:0] == 7'h00) && !st_q.pending;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("status not cleared by read");

    property p_mask;
        st_q.pending == |(st_q.dma_status & st_q.dma_interrupt_enable & STATUS_INT_MASK);
    endproperty
    a_mask: assert property (p_mask) else $error("pending flag disagrees with masked status");

    property p_fifo_empty;
        evt_i.fifo_empty |=> st_q.dma_status[DFE_BIT] ##1 (st_q.pending ==
            |(st_q.dma_status[6:0] & st_q.dma_interrupt_enable[6:0]));
    endproperty
    a_fifo_empty: assert property (p_fifo_empty) else $error("fifo empty bit wrong");

    property p_parity;
        evt_i.master_parity_err |=> st_q.dma_status[MASTER_PARITY_ERROR_FLAG_BIT] == $past(st_q.control[CTL_MPEE_BIT])
            || $past(st_q.dma_status[MASTER_PARITY_ERROR_FLAG_BIT]);
    endproperty
    a_parity: assert property (p_parity) else $error("parity bit wrong");

    property p_bus_fault;
        evt_i.bus_fault |=> st_q.dma_status[BF_BIT];
    endproperty
    a_bus_fault: assert property (p_bus_fault) else $error("bus fault not flagged");

    property p_single_step;
        evt_i.instr_done_ok && st_q.control[CTL_SSTEP_BIT] |=> st_q.dma_status[SSI_BIT];
    endproperty
    a_single_step: assert property (p_single_step) else $error("single step not flagged");

    property p_zero_move;
        instr_i.valid && (instr_i.cmd[7:6] == TYPE_BLOCK) && (instr_i.dbc == 24'h000000)
            |=> st_q.dma_status[IID_BIT];
    endproperty
    a_zero_move: assert property (p_zero_move) else $error("zero count move not flagged");

    property p_lost;
        s_arb_seen_sel |=> st_q.scsi_status_zero[3] && !st_q.scsi_status_zero[4];
    endproperty
    a_lost: assert property (p_lost) else $error("lost arbitration not shown");

    property p_won;
        $rose(st_q.scsi_status_zero[2]) |-> $past(st_q.control[CTL_FULL_ARB_BIT]);
    endproperty
    a_won: assert property (p_won) else $error("won outside full arbitration");

    property p_reset_line;
        !scsi_rst_n [*4] |-> st_q.scsi_status_zero[1];
    endproperty
    a_reset_line: assert property (p_reset_line) else $error("reset line not shown");

    property p_aborted;
        evt_i.abort_done && st_q.abort_req |=> st_q.dma_status[ABORTED_FLAG_BIT];
    endproperty
    a_aborted: assert property (p_aborted) else $error("abort not flagged");

    property p_script_int;
        evt_i.int_instr_true |=> st_q.dma_status[SIR_BIT];
    endproperty
    a_script_int: assert property (p_script_int) else $error("interrupt instruction not flagged");

    property p_extra_parity;
        evt_i.extra_parity_err |=> st_q.dma_status[EXTRA_PARITY_ERROR_FLAG_BIT];
    endproperty
    a_extra_parity: assert property (p_extra_parity) else $error("extra parity error not flagged");

    property p_illegal_op;
        evt_i.illegal_opcode |=> st_q.dma_status[IID_BIT];
    endproperty
    a_illegal_op: assert property (p_illegal_op) else $error("illegal opcode not flagged");

    property p_wait_disc;
        evt_i.wait_disc_req |=> st_q.dma_status[IID_BIT];
    endproperty
    a_wait_disc: assert property (p_wait_disc) else $error("wait disconnect request not flagged");

    property p_xfer_rsvd;
        instr_i.valid && (instr_i.cmd[7:6] == TYPE_XFER) && instr_i.dbc[RSVD22_BIT]
            |=> st_q.dma_status[IID_BIT];
    endproperty
    a_xfer_rsvd: assert property (p_xfer_rsvd) else $error("reserved transfer bit not flagged");

    property p_ls_count;
        instr_i.valid && (instr_i.cmd[7:6] == TYPE_MEM) && instr_i.cmd[LS_BIT]
            && ((instr_i.dbc < LS_MIN) || (instr_i.dbc > LS_MAX)) |=> st_q.dma_status[IID_BIT];
    endproperty
    a_ls_count: assert property (p_ls_count) else $error("load store count not flagged");

    property p_mm_align;
        instr_i.valid && (instr_i.cmd[7:6] == TYPE_MEM) && !instr_i.cmd[LS_BIT]
            && (instr_i.src_addr != instr_i.dst_addr) |=> st_q.dma_status[IID_BIT];
    endproperty
    a_mm_align: assert property (p_mm_align) else $error("memory move alignment not flagged");

    property p_latches;
        aresetn |=> st_q.scsi_status_zero[7:5] == $past({scsi_i.in_latch_low_full, scsi_i.out_hold_low_full,
            scsi_i.out_latch_low_full});
    endproperty
    a_latches: assert property (p_latches) else $error("latch full bits wrong");

    property p_fifo_quiet;
        (st_q.dma_status[6:0] == 7'h00) |-> !st_q.pending;
    endproperty
    a_fifo_quiet: assert property (p_fifo_quiet) else $error("pending without interrupt status");

    property p_arb_run;
        (st_q.arb != ARB_RUN) && scsi_i.arb_request && scsi_i.bus_free |=> st_q.scsi_status_zero[4];
    endproperty
    a_arb_run: assert property (p_arb_run) else $error("arbitration in progress not shown");

endmodule // dsr_status_regs

`default_nettype wire

/* verification/test_dsr_status_regs.sv */
// self-checking bench for the dma and scsi status register bank
// assumes the axi4-lite slave, event inputs and pins of dsr_status_regs on one 100 MHz clock
`timescale 1ns/1ps
`default_nettype none

module test_dsr_status_regs;
    import dsr_pkg::*;
    // =====================================================================
    // signals and design
    logic aclk, aresetn, rst_n, sdp_n, sel_n, pend, aborted_flag;
    dsr_axi_req_t req;
    dsr_axi_rsp_t rsp;
    dsr_evt_t evt;
    dsr_instr_t ins;
    dsr_scsi_t scsi;
    int fails, checked, cyc;
    logic [31:0] d;
    logic [7:0] en;
    logic [1:0] r;
    logic [7:0] ic[15] = '{8'h00, 8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'hE0, 8'hE4, 8'hC2, 8'hC0, 8'hC0,
        8'hE0, 8'hE0, 8'hE0};
    logic [23:0] idb[15] = '{24'h000000, 24'h000001, 24'h040000, 24'h220000, 24'h400000, 24'h010000,
        24'h000000, 24'h000005, 24'h000001, 24'h000004, 24'h000004, 24'h000004, 24'h000004,
        24'h000001, 24'h000001};
    logic [14:0] itm = 15'h0024;
    logic [14:0] ia = 15'h1400;
    logic [14:0] ill = 15'h77BD;

    dsr_status_regs dsr_status_regs_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_i(req), .s_axi_o(rsp),
        .evt_i(evt), .instr_i(ins), .scsi_i(scsi), .scsi_rst_n(rst_n), .scsi_low_byte_parity_line_n(sdp_n),
        .scsi_sel_n(sel_n), .dma_interrupt_pending(pend), .abort_request(aborted_flag));

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            test_done();
        end
    end
    // =====================================================================
    // tasks
    task automatic test_done();
        if (fails == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [3:0] s, output logic [1:0] rs);
        int n;
        n = 0;
        rs = 2'h1;
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= {24'h000000, v};
        req.wstrb <= s;
        do begin
            @(posedge aclk);
            n++;
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1 && n < 40);
        if (rsp.bvalid === 1'b1) rs = rsp.bresp;
        else fails++;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        int n;
        if (a == 8'h30) tick(12);
        n = 0;
        v = 32'hFFFFFFFF;
        rs = 2'h1;
        req.arvalid <= 1'b1;
        req.araddr <= a;
        do begin
            @(posedge aclk);
            n++;
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1 && n < 40);
        if (rsp.rvalid === 1'b1) begin
            v = rsp.rdata;
            rs = rsp.rresp;
        end else fails++;
    endtask

    task automatic pulse(input logic [8:0] m);
        evt <= evt | m;
        @(posedge aclk);
        evt <= evt & ~m;
    endtask
    // =====================================================================
    // scenarios
    initial begin
        int b;
        logic [31:0] v;
        aresetn = 1'b0;
        req = '0;
        evt = 9'h100;
        ins = '0;
        scsi = '0;
        rst_n = 1'b1;
        sdp_n = 1'b1;
        sel_n = 1'b1;
        fails = 0;
        checked = 0;
        cyc = 0;
        void'($urandom(90));
        tick(4);
        aresetn <= 1'b1;
        req.bready <= 1'b1;
        req.rready <= 1'b1;
        tick(2);
        rd(8'h30, d, r); chk(d, 32'h00000080);
        rd(8'h34, d, r); chk(d, 32'h00000000);
        en = 8'($urandom);
        wr(8'h80, en, 4'hF, r); chk(r, RESP_OKAY);
        rd(8'h80, d, r); chk(d, {24'h000000, en & 8'h7F});
        wr(8'h84, 8'h89, 4'hF, r); chk(aborted_flag, 1'b1);
        rd(8'h84, d, r); chk(d, 32'h00000009);
        for (int k = 0; k < 8; k++) begin
            b = (k == 0) ? 0 : k - 1;
            pulse(9'h001 << k);
            tick(2);
            chk(pend, en[b]);
            rd(8'h30, d, r); chk(d, 32'h00000080 | (32'h00000001 << b));
            rd(8'h30, d, r); chk(d, 32'h00000080);
            chk(pend, 1'b0);
        end
        chk(aborted_flag, 1'b0);
        wr(8'h84, 8'h00, 4'hF, r);
        pulse(9'h080);
        tick(2);
        rd(8'h30, d, r); chk(d, 32'h00000080);
        evt.fifo_empty <= 1'b0;
        wr(8'h80, 8'h7F, 4'hF, r);
        tick(2);
        rd(8'h30, d, r); chk(d, 32'h00000000);
        chk(pend, 1'b0);
        evt.fifo_empty <= 1'b1;
        tick(2);
        for (int k = 0; k < 15; k++) begin
            ins.valid <= 1'b1;
            ins.cmd <= ic[k];
            ins.dbc <= idb[k];
            ins.target_mode <= itm[k];
            ins.mem_is_op_regs <= (k == 13);
            ins.reg_addr <= {1'b0, ia[k] | (k == 14)};
            ins.mem_addr <= {1'b0, ia[k]};
            ins.src_addr <= {1'b0, ia[k]};
            @(posedge aclk);
            ins.valid <= 1'b0;
            tick(2);
            rd(8'h30, d, r); chk(d, {24'h000000, 7'h40, ill[k]} | 32'h00000080);
        end
        wr(8'h30, 8'hFF, 4'hF, r); chk(r, RESP_SLVERR);
        rd(8'h30, d, r); chk(d, 32'h00000080);
        wr(8'h3C, 8'hFF, 4'hF, r); chk(r, RESP_DECERR);
        rd(8'h3C, d, r); chk({d[7:0], 6'h00, r}, {8'h00, 6'h00, RESP_DECERR});
        wr(8'h80, 8'h00, 4'h0, r); chk(r, RESP_OKAY);
        rd(8'h80, d, r); chk(d, 32'h0000007F);
        repeat (4) begin
            v = $urandom;
            scsi <= {v[2:0], 3'b000};
            tick(2);
            rd(8'h34, d, r); chk(d, {24'h000000, v[2:0], 5'h00});
        end
        scsi <= '0;
        rst_n <= 1'b0;
        sdp_n <= 1'b0;
        tick(4);
        rd(8'h34, d, r); chk(d, 32'h00000003);
        rst_n <= 1'b1;
        sdp_n <= 1'b1;
        tick(4);
        wr(8'h84, 8'h40, 4'hF, r);
        rd(8'h34, d, r); chk(d, 32'h00000002);
        wr(8'h84, 8'h00, 4'hF, r);
        scsi <= 6'h06;
        tick(4);
        rd(8'h34, d, r); chk(d, 32'h00000010);
        scsi <= 6'h05;
        tick(4);
        rd(8'h34, d, r); chk(d, 32'h00000000);
        scsi <= 6'h06;
        tick(4);
        sel_n <= 1'b0;
        scsi <= 6'h04;
        tick(6);
        rd(8'h34, d, r); chk(d, 32'h00000008);
        sel_n <= 1'b1;
        wr(8'h84, 8'h02, 4'hF, r);
        scsi <= 6'h06;
        tick(4);
        scsi <= 6'h05;
        tick(4);
        rd(8'h34, d, r); chk(d, 32'h00000004);
        aresetn <= 1'b0;
        tick(2);
        aresetn <= 1'b1;
        tick(2);
        rd(8'h80, d, r); chk(d, 32'h00000000);
        rd(8'h84, d, r); chk(d, 32'h00000000);
        rd(8'h34, d, r); chk(d, 32'h00000000);
        test_done();
    end
endmodule // test_dsr_status_regs

`default_nettype wire
